// >>> src/csc_pkg.sv
// shared constants and types for the clock synthesizer configuration port
package csc_pkg;
    localparam int                 CSC_NUM_BYTES    = 8;
    localparam logic [7:0]         CSC_SLAVE_ADDR   = 8'hD2;
    localparam int                 CSC_CMD_SEL_BIT  = 7;
    localparam logic [3:0]         CSC_BYTE_BITS    = 4'h8;
    // byte 0 at the low end; bytes 6 and 7 come up clear
    localparam logic [63:0]        CSC_REG_DEFAULTS = 64'h0000_0007_00FF_FEFF;
    // strap code order is C,B,A
    localparam logic [2:0]         CSC_FS_100       = 3'h5;
    localparam logic [2:0]         CSC_FS_133       = 3'h1;
    localparam logic [2:0]         CSC_FS_166       = 3'h3;
    localparam logic [2:0]         CSC_FS_200       = 3'h2;
    localparam logic [7:0]         CSC_MHZ_100      = 8'h64;
    localparam logic [7:0]         CSC_MHZ_133      = 8'h85;
    localparam logic [7:0]         CSC_MHZ_166      = 8'hA6;
    localparam logic [7:0]         CSC_MHZ_200      = 8'hC8;
    localparam logic [5:0]         CSC_STRAP_IDLE   = 6'h20;
    localparam logic [1:0]         CSC_BUS_IDLE     = 2'h3;

    typedef enum logic [9:0] {
        CSC_IDLE     = 10'h001,
        CSC_ADDR     = 10'h002,
        CSC_ADDR_ACK = 10'h004,
        CSC_CMD      = 10'h008,
        CSC_CMD_ACK  = 10'h010,
        CSC_WR       = 10'h020,
        CSC_WR_ACK   = 10'h040,
        CSC_RD       = 10'h080,
        CSC_RD_ACK   = 10'h100,
        CSC_IGNORE   = 10'h200
    } csc_slave_state_type;
endpackage : csc_pkg

// >>> src/csc_strap_if.sv
// latched strap results passed from the strap latch to the port top
`timescale 1ns/1ps
interface csc_strap_if;
    logic       captured;
    logic       test_mode;
    logic       test_drive;
    logic       req_as_outputs;
    logic       pd_request;
    logic [2:0] fs_code;
    modport latch (output captured, test_mode, test_drive, req_as_outputs, pd_request, fs_code);
    modport user  (input  captured, test_mode, test_drive, req_as_outputs, pd_request, fs_code);
endinterface : csc_strap_if

// >>> src/csc_sync.sv
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module csc_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } csc_sync_state_type;

    csc_sync_state_type s_r;
    csc_sync_state_type s_nxt;

    // meta feeds only the second stage
    always_comb begin
        s_nxt.meta   = async_in;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_r <= {RST_VAL, RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_out = s_r.stable;
endmodule : csc_sync

// >>> src/csc_strap_latch.sv
// one-shot strap capture on the cpu rail power-good strobe
`timescale 1ns/1ps
module csc_strap_latch (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       good_n_s,
    input  wire logic [2:0] fs_s,
    input  wire logic       test_s,
    input  wire logic       req_s,
    csc_strap_if.latch      st_if
);
    import csc_pkg::*;

    typedef struct packed {
        logic       captured;
        logic       test_mode;
        logic       req_out;
        logic       pd;
        logic [2:0] fs;
    } csc_strap_state_type;

    csc_strap_state_type s_r;
    csc_strap_state_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!s_r.captured && !good_n_s) begin
            s_nxt.captured  = 1'b1;                 // RL1
            s_nxt.fs        = fs_s;                 // RL1
            s_nxt.test_mode = test_s;               // RL4
            s_nxt.req_out   = req_s;                // RL5
        end else if (s_r.captured && s_r.test_mode) begin
            s_nxt.fs = fs_s;                        // RL2
        end
        // pin turns into an active-high power-down request
        s_nxt.pd = s_nxt.captured & good_n_s;       // RL17
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign st_if.captured       = s_r.captured;
    assign st_if.test_mode      = s_r.test_mode;
    assign st_if.test_drive     = s_r.test_mode & s_r.fs[1];   // RL18
    assign st_if.req_as_outputs = s_r.req_out;
    assign st_if.pd_request     = s_r.pd;
    assign st_if.fs_code        = s_r.fs;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_capture;
        !s_r.captured && !good_n_s |=> s_r.captured && s_r.fs == $past(fs_s);
    endproperty
    a_capture: assert property (p_capture) else $error("straps not captured"); // RL1

    property p_hold;
        s_r.captured && !s_r.test_mode |=> $stable(s_r.fs) && $stable(s_r.req_out);
    endproperty
    a_hold: assert property (p_hold) else $error("straps moved after capture"); // RL2

    property p_pd;
        !s_r.captured |-> !s_r.pd;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down before capture"); // RL17
endmodule : csc_strap_latch

// >>> src/csc_config_port.sv
// clock synthesizer config port: strap capture and two-wire control byte slave
// Behaviour
// RL1: capture frequency straps when the power-good strobe is first seen low
// RL2: after capture ignore strobe and strap changes, except in test mode
// RL3: latched code C,B,A selects cpu clock 100, 133, 166 or 200 MHz
// RL4: test strap high at capture puts the device in test mode
// RL5: request-pin mode strap at capture: 0 request inputs, 1 clock outputs
// RL6: every control byte loads its default at power-up
// RL7: host changes bytes only at initialisation, never for power management
// RL8: support byte write, byte read, block write and block read
// RL9: block bytes move in ascending index, msb first, may stop after any byte
// RL10: answer only to bus address D2h including the direction bit
// RL11: command bit 7 low selects block, high selects single byte
// RL12: command bits 6..0 index single-byte transfers; zero for blocks
// RL13: block write: address, command, optional count, acked data, stop
// RL14: block read returns a count byte then data, host acks each
// RL15: host nacks the last read byte then stops
// RL16: byte write and byte read sequences with repeated start for reads
// RL17: after capture the strobe pin is an active-high power-down request
// RL18: in test mode select B chooses tri-state or reference divided by N
// RL19: foreign address: no acknowledge and rest of transaction ignored
`timescale 1ns/1ps
module csc_config_port #(
    parameter int                     NUM_BYTES    = csc_pkg::CSC_NUM_BYTES,
    parameter logic [NUM_BYTES*8-1:0] REG_DEFAULTS = csc_pkg::CSC_REG_DEFAULTS
) (
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe_n,
    input  wire logic                   cpu_rail_good_n,
    input  wire logic                   freq_sel_a,
    input  wire logic                   freq_sel_b,
    input  wire logic                   freq_sel_c,
    input  wire logic                   test_mode_strap,
    input  wire logic                   req_pin_mode_strap,
    input  wire logic                   count_skip,
    output logic [NUM_BYTES*8-1:0]      ctrl_bytes,
    output logic                        strap_done,
    output logic                        test_mode,
    output logic                        test_out_drive,
    output logic                        req_pins_as_outputs,
    output logic                        power_down_request,
    output logic [7:0]                  cpu_freq_mhz,
    output logic                        cpu_freq_valid
);
    import csc_pkg::*;

    localparam logic [7:0] NB8 = 8'(NUM_BYTES);

    typedef struct packed {
        csc_slave_state_type          st;
        logic                         scl_q;
        logic                         sda_q;
        logic [3:0]                   cnt;
        logic [7:0]                   sh;
        logic [7:0]                   tx;
        logic                         rw;
        logic                         block;
        logic                         cnt_pend;
        logic                         cnt_out;
        logic                         nack;
        logic                         sda_low;
        logic [6:0]                   idx;
        logic [7:0]                   mhz;
        logic                         mhz_ok;
        logic [NUM_BYTES-1:0][7:0]    regs;
    } csc_top_state_type;

    csc_top_state_type s_r;
    csc_top_state_type s_nxt;

    logic [1:0] bus_s;
    logic [5:0] strap_s;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       byte_done;
    logic       cmd_done;
    logic       wr_commit;
    logic [6:0] nidx;

    csc_strap_if u_st_if ();

    // ------------------------------------------------------------
    // pin synchronisers and strap latch
    // ------------------------------------------------------------
    csc_sync #(.W(2), .RST_VAL(CSC_BUS_IDLE)) u_bus_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in ({scl_in, sda_in}),
        .sync_out (bus_s)
    );

    // strobe resets to its idle high so reset never fakes a capture
    csc_sync #(.W(6), .RST_VAL(CSC_STRAP_IDLE)) u_strap_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in ({cpu_rail_good_n, test_mode_strap, req_pin_mode_strap,
                    freq_sel_c, freq_sel_b, freq_sel_a}),
        .sync_out (strap_s)
    );

    csc_strap_latch u_strap (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .good_n_s (strap_s[5]),
        .fs_s     (strap_s[2:0]),
        .test_s   (strap_s[4]),
        .req_s    (strap_s[3]),
        .st_if    (u_st_if)
    );

    // ------------------------------------------------------------
    // bus event detection
    // ------------------------------------------------------------
    assign scl_s     = bus_s[1];
    assign sda_s     = bus_s[0];
    assign scl_rise  = scl_s & ~s_r.scl_q;
    assign scl_fall  = ~scl_s & s_r.scl_q;
    // both samples of scl high so a joint rise after reset is no event
    assign start_det = scl_s & s_r.scl_q & s_r.sda_q & ~sda_s;
    assign stop_det  = scl_s & s_r.scl_q & ~s_r.sda_q & sda_s;
    assign byte_done = scl_fall && s_r.cnt == CSC_BYTE_BITS;
    assign cmd_done  = byte_done && s_r.st == CSC_CMD;
    assign nidx      = (s_r.block && !s_r.cnt_out) ? s_r.idx + 7'h01 : s_r.idx;

    // ------------------------------------------------------------
    // slave sequencer and control bytes
    // ------------------------------------------------------------
    always_comb begin
        s_nxt       = s_r;
        wr_commit   = 1'b0;
        s_nxt.scl_q = scl_s;
        s_nxt.sda_q = sda_s;
        case (u_st_if.fs_code)                                  // RL3
            CSC_FS_100: s_nxt.mhz = CSC_MHZ_100;
            CSC_FS_133: s_nxt.mhz = CSC_MHZ_133;
            CSC_FS_166: s_nxt.mhz = CSC_MHZ_166;
            CSC_FS_200: s_nxt.mhz = CSC_MHZ_200;
            default:    s_nxt.mhz = 8'h00;
        endcase
        s_nxt.mhz_ok = u_st_if.captured && s_nxt.mhz != 8'h00;
        if (start_det) begin
            s_nxt.st      = CSC_ADDR;                           // RL16
            s_nxt.cnt     = 4'h0;
            s_nxt.sda_low = 1'b0;
        end else if (stop_det) begin
            s_nxt.st      = CSC_IDLE;                           // RL9
            s_nxt.sda_low = 1'b0;
        end else begin
            case (s_r.st)
                CSC_ADDR, CSC_CMD, CSC_WR: begin
                    if (scl_rise) begin
                        s_nxt.sh  = {s_r.sh[6:0], sda_s};       // RL9
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end else if (byte_done) begin
                        s_nxt.cnt     = 4'h0;
                        s_nxt.sda_low = 1'b1;
                        if (s_r.st == CSC_ADDR) begin
                            if (s_r.sh[7:1] == CSC_SLAVE_ADDR[7:1]) begin   // RL10
                                s_nxt.rw = s_r.sh[0];
                                s_nxt.st = CSC_ADDR_ACK;
                            end else begin
                                s_nxt.st      = CSC_IGNORE;     // RL19
                                s_nxt.sda_low = 1'b0;           // RL19
                            end
                        end else if (s_r.st == CSC_CMD) begin
                            s_nxt.block    = ~s_r.sh[CSC_CMD_SEL_BIT];       // RL11
                            s_nxt.idx      = s_nxt.block ? 7'h00 : s_r.sh[6:0]; // RL12
                            s_nxt.cnt_pend = s_nxt.block & ~count_skip;     // RL13
                            s_nxt.st       = CSC_CMD_ACK;
                        end else begin
                            if (s_r.cnt_pend) begin
                                s_nxt.cnt_pend = 1'b0;          // RL13
                            end else begin
                                wr_commit = {1'b0, s_r.idx} < NB8;
                                if (wr_commit) begin
                                    s_nxt.regs[s_r.idx] = s_r.sh;       // RL8
                                end
                                if (s_r.block) begin
                                    s_nxt.idx = s_r.idx + 7'h01;        // RL9
                                end
                            end
                            s_nxt.st = CSC_WR_ACK;
                        end
                    end
                end
                CSC_ADDR_ACK: begin
                    if (scl_fall) begin
                        s_nxt.cnt = 4'h0;
                        if (s_r.rw) begin
                            s_nxt.cnt_out = s_r.block;          // RL14
                            s_nxt.tx      = s_r.block ? NB8 :
                                            ({1'b0, s_r.idx} < NB8 ? s_r.regs[s_r.idx] : 8'h00);
                            s_nxt.sda_low = ~s_nxt.tx[7];
                            s_nxt.st      = CSC_RD;             // RL16
                        end else begin
                            s_nxt.sda_low = 1'b0;
                            s_nxt.st      = CSC_CMD;
                        end
                    end
                end
                CSC_CMD_ACK, CSC_WR_ACK: begin
                    if (scl_fall) begin
                        s_nxt.sda_low = 1'b0;
                        s_nxt.st      = CSC_WR;
                    end
                end
                CSC_RD: begin
                    if (scl_rise) begin
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end else if (byte_done) begin
                        s_nxt.sda_low = 1'b0;
                        s_nxt.st      = CSC_RD_ACK;
                    end else if (scl_fall) begin
                        s_nxt.tx      = {s_r.tx[6:0], 1'b0};   // RL9
                        s_nxt.sda_low = ~s_r.tx[6];
                    end
                end
                CSC_RD_ACK: begin
                    if (scl_rise) begin
                        s_nxt.nack = sda_s;
                    end else if (scl_fall) begin
                        if (s_r.nack) begin
                            s_nxt.st = CSC_IGNORE;              // RL15
                        end else begin
                            s_nxt.cnt_out = 1'b0;
                            s_nxt.idx     = nidx;               // RL14
                            s_nxt.tx      = {1'b0, nidx} < NB8 ? s_r.regs[nidx] : 8'h00;
                            s_nxt.sda_low = ~s_nxt.tx[7];
                            s_nxt.cnt     = 4'h0;
                            s_nxt.st      = CSC_RD;
                        end
                    end
                end
                CSC_IDLE, CSC_IGNORE: begin
                    s_nxt.sda_low = 1'b0;
                end
                default: begin
                    s_nxt.st      = CSC_IDLE;
                    s_nxt.sda_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_r       <= '0;
            s_r.st    <= CSC_IDLE;
            s_r.scl_q <= 1'b1;
            s_r.sda_q <= 1'b1;
            s_r.regs  <= REG_DEFAULTS;                          // RL6
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // open drain: only ever pulls low
    assign sda_out             = 1'b0;
    assign sda_oe_n            = ~s_r.sda_low;
    assign ctrl_bytes          = s_r.regs;
    assign strap_done          = u_st_if.captured;
    assign test_mode           = u_st_if.test_mode;             // RL4
    assign test_out_drive      = u_st_if.test_drive;            // RL18
    assign req_pins_as_outputs = u_st_if.req_as_outputs;        // RL5
    assign power_down_request  = u_st_if.pd_request;            // RL17
    assign cpu_freq_mhz        = s_r.mhz;
    assign cpu_freq_valid      = s_r.mhz_ok;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_ignore_quiet;
        s_r.st == CSC_IGNORE |-> sda_oe_n;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet) else $error("ignored frame driven"); // RL19

    property p_addr_ack;
        byte_done && s_r.st == CSC_ADDR && s_r.sh[7:1] == CSC_SLAVE_ADDR[7:1]
            |=> s_r.st == CSC_ADDR_ACK && !sda_oe_n;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked"); // RL10

    property p_cmd_block;
        cmd_done && !s_r.sh[7] |=> s_r.block && s_r.idx == 7'h00;
    endproperty
    a_cmd_block: assert property (p_cmd_block) else $error("block command misdecoded"); // RL11

    property p_cmd_index;
        cmd_done && s_r.sh[7] |=> !s_r.block && s_r.idx == $past(s_r.sh[6:0]);
    endproperty
    a_cmd_index: assert property (p_cmd_index) else $error("byte index misdecoded"); // RL12

    property p_defaults;
        $past(reset) |-> s_r.regs == REG_DEFAULTS;
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults not loaded"); // RL6

    property p_write_store;
        wr_commit |=> s_r.regs[$past(s_r.idx)] == $past(s_r.sh);
    endproperty
    a_write_store: assert property (p_write_store) else $error("write not stored"); // RL13

    property p_block_step;
        wr_commit && s_r.block |=> s_r.idx == $past(s_r.idx) + 7'h01;
    endproperty
    a_block_step: assert property (p_block_step) else $error("block index not stepped"); // RL9

    property p_count_first;
        scl_fall && s_r.st == CSC_ADDR_ACK && s_r.rw && s_r.block
            |=> s_r.st == CSC_RD && s_r.tx == NB8;
    endproperty
    a_count_first: assert property (p_count_first) else $error("count not sent first"); // RL14

    property p_rd_stable;
        s_r.st == CSC_RD && scl_s && s_r.scl_q |-> $stable(sda_oe_n);
    endproperty
    a_rd_stable: assert property (p_rd_stable) else $error("read data moved with clock high"); // RL16

    property p_nack_end;
        scl_fall && s_r.st == CSC_RD_ACK && s_r.nack |=> s_r.st == CSC_IGNORE ##1 sda_oe_n;
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("read not ended by nack"); // RL15
endmodule : csc_config_port

// >>> bench/csc_host_model.sv
// two-wire host controller model that drives serial clock and data
`timescale 1ns/1ps
module csc_host_model (
    input  wire logic sys_clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_low
);
    // ------------------------------------------------------------
    // bus phases, all changes just after a falling system clock edge
    // ------------------------------------------------------------
    initial begin
        scl     = 1'h1;
        sda_low = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    // start and repeated start; the long low phase lets the slave drop its ack
    task automatic start();
        if (!scl) begin
            sda_low = 1'h0;
            tick(8);
            scl = 1'h1;
            tick(4);
        end
        sda_low = 1'h1;
        tick(4);
        scl = 1'h0;
    endtask : start
    task automatic stop();
        tick(2);
        sda_low = 1'h1;
        tick(2);
        scl = 1'h1;
        tick(4);
        sda_low = 1'h0;
        tick(8);
    endtask : stop
    task automatic clk_bit(input logic b, output logic s);
        tick(2);
        sda_low = ~b;
        tick(2);
        scl = 1'h1;
        tick(3);
        s = sda_wire;
        tick(1);
        scl = 1'h0;
    endtask : clk_bit
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'h1, s);
        ack = ~s;
    endtask : send
    task automatic recv(output logic [7:0] b, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'h1, b[i]);
        end
        clk_bit(last, s);
    endtask : recv
endmodule : csc_host_model

// >>> bench/tb.sv
// self-checking bench for the clock synthesizer config port
`timescale 1ns/1ps
module tb;
    import csc_pkg::*;
    logic        sys_clk, reset, sda_wire, scl, sda_low, sda_oe_n, sda_out, count_skip;
    logic        cpu_rail_good_n, freq_sel_a, freq_sel_b, freq_sel_c;
    logic        test_mode_strap, req_pin_mode_strap, strap_done, test_mode;
    logic        test_out_drive, req_pins_as_outputs, power_down_request, cpu_freq_valid;
    logic [63:0] ctrl_bytes;
    logic [7:0]  cpu_freq_mhz;
    int          n_mismatch, checks_done, cycles;
    // open drain wire with pull-up; the device level counts only while enabled
    assign sda_wire = (sda_low | (~sda_oe_n & ~sda_out)) ? 1'h0 : 1'h1;
    csc_host_model host (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
    csc_config_port uut (.sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cpu_rail_good_n(cpu_rail_good_n),
        .freq_sel_a(freq_sel_a), .freq_sel_b(freq_sel_b), .freq_sel_c(freq_sel_c),
        .test_mode_strap(test_mode_strap), .req_pin_mode_strap(req_pin_mode_strap),
        .count_skip(count_skip), .ctrl_bytes(ctrl_bytes), .strap_done(strap_done),
        .test_mode(test_mode), .test_out_drive(test_out_drive),
        .req_pins_as_outputs(req_pins_as_outputs), .power_down_request(power_down_request),
        .cpu_freq_mhz(cpu_freq_mhz), .cpu_freq_valid(cpu_freq_valid));
    // ------------------------------------------------------------
    // clock, timeout, checking
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] b);
        logic ack;
        host.send(b, ack);
        chk(ack, 1'h1);
    endtask : wr
    task automatic do_reset();
        reset = 1'h1;
        cpu_rail_good_n = 1'h1;
        test_mode_strap = 1'h0;
        host.tick(6);
        reset = 1'h0;
        host.tick(3);
    endtask : do_reset
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_byte();
        logic [7:0] b;
        host.start();
        wr(8'hD2);
        wr(8'h82);
        wr(8'h5A);
        host.stop();
        chk(ctrl_bytes[23:16], 8'h5A);
        host.start();
        wr(8'hD2);
        wr(8'h82);
        host.start();
        wr(8'hD3);
        host.recv(b, 1'h1);
        host.stop();
        chk(b, 8'h5A);
    endtask : t_byte
    task automatic t_block();
        logic [7:0]  b;
        logic [31:0] e;
        e = {8'hA3, 8'hB2, 8'hB1, 8'h08};
        count_skip = 1'h0;
        host.start();
        wr(8'hD2);
        wr(8'h00);
        wr(8'h03);
        wr(8'hA1);
        wr(8'hA2);
        wr(8'hA3);
        host.stop();
        chk(ctrl_bytes, {CSC_REG_DEFAULTS[63:24], 24'hA3A2A1});
        count_skip = 1'h1;
        host.start();
        wr(8'hD2);
        wr(8'h00);
        wr(8'hB1);
        wr(8'hB2);
        host.stop();
        chk(ctrl_bytes[23:0], 24'hA3B2B1);
        host.start();
        wr(8'hD2);
        wr(8'h00);
        host.start();
        wr(8'hD3);
        for (int i = 0; i < 4; i++) begin
            host.recv(b, i == 3);
            chk(b, e[8*i+:8]);
        end
        host.stop();
    endtask : t_block
    task automatic t_foreign();
        logic ack;
        host.start();
        host.send(8'hD4, ack);
        chk(ack, 1'h0);
        host.send(8'h80, ack);
        host.send(8'h11, ack);
        chk(ack, 1'h0);
        host.stop();
        chk(ctrl_bytes[7:0], 8'hB1);
    endtask : t_foreign
    task automatic t_strap(input logic [2:0] code, input logic [7:0] mhz, input logic req);
        do_reset();
        chk(ctrl_bytes, CSC_REG_DEFAULTS);
        chk(strap_done, 1'h0);
        {freq_sel_c, freq_sel_b, freq_sel_a} = code;
        req_pin_mode_strap = req;
        cpu_rail_good_n = 1'h0;
        host.tick(6);
        chk({strap_done, cpu_freq_valid, test_mode}, 3'h6);
        chk(cpu_freq_mhz, mhz);
        chk(req_pins_as_outputs, req);
        {freq_sel_c, freq_sel_b, freq_sel_a} = ~code;
        req_pin_mode_strap = ~req;
        cpu_rail_good_n = 1'h1;
        host.tick(6);
        chk({cpu_freq_mhz, req_pins_as_outputs}, {mhz, req});
        chk(power_down_request, 1'h1);
        cpu_rail_good_n = 1'h0;
        host.tick(6);
        chk(power_down_request, 1'h0);
    endtask : t_strap
    task automatic t_test();
        do_reset();
        {freq_sel_c, freq_sel_b, freq_sel_a} = 3'h0;
        test_mode_strap = 1'h1;
        cpu_rail_good_n = 1'h0;
        host.tick(6);
        chk({test_mode, test_out_drive, cpu_freq_valid}, 3'h4);
        {freq_sel_b, freq_sel_a} = 2'h3;
        host.tick(6);
        chk(test_out_drive, 1'h1);
        chk(cpu_freq_mhz, CSC_MHZ_166);
    endtask : t_test
    initial begin
        {reset, count_skip, freq_sel_a, freq_sel_b, freq_sel_c, req_pin_mode_strap} = 6'h20;
        n_mismatch = 0;
        checks_done = 0;
        cycles = 0;
        do_reset();
        // all port traffic happens right after reset, as at system start
        t_byte();
        t_block();
        t_foreign();
        t_strap(CSC_FS_100, CSC_MHZ_100, 1'h0);
        t_strap(CSC_FS_133, CSC_MHZ_133, 1'h1);
        t_strap(CSC_FS_166, CSC_MHZ_166, 1'h0);
        t_strap(CSC_FS_200, CSC_MHZ_200, 1'h1);
        t_test();
        report_and_stop();
    end
endmodule : tb
